// ===== rwd_top.sv
// Refreshable watchdog counter with register port, halt handling and interrupt.
// Assumes option bits and halt/wake signals arrive from other clock domains or pins.
//
// Overview of operation
// - Counter decrements every 16384 clock cycles
// - Low six bits set remaining periods
// - Rollover 40h to 3Fh pulls reset low while enabled
// - Counter runs even while watchdog disabled
// - Control write never restarts the prescaler
// - Reset leaves watchdog disabled unless hardware option
// - Enable bit cannot be cleared by software
// - Enable with top bit clear resets immediately
// - Halt while active causes device reset, except with oscillator interrupt enabled and halt option clear
// - Option bit selects reset on halt
// - Option bit enables watchdog in hardware
// - Halt with halt option and oscillator interrupt clear: one decrement, then stop
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rwd_top
  import rwd_pkg::*;
(
  input  wire logic       MCLK_IN,
  input  wire logic       RESET_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WRITE_IN,
  input  wire logic       READ_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic       HW_WATCHDOG_OPT_IN,
  input  wire logic       HALT_RESET_OPT_IN,
  input  wire logic       OSC_INT_ENABLE_IN,
  input  wire logic       HALT_IN,
  input  wire logic       EXT_WAKE_IN,
  input  wire logic       WAKE_LONG_IN,
  output logic            RESET_N_OUT,
  output logic            RESET_OE_N_OUT,
  output logic            IRQ_OUT
);
  logic [1:0]            hw_opt_sync;
  logic [1:0]            halt_opt_sync;
  logic [1:0]            oie_sync;
  logic [1:0]            halt_sync;
  logic [1:0]            wake_sync;
  logic [1:0]            long_sync;
  logic                  halt_prev;
  logic                  halt_edge;
  logic                  wake_prev;
  logic                  wake_edge;
  logic                  opt_loaded;
  logic [13:0]           prescale;
  logic                  tick;
  logic [6:0]            counter;
  logic                  enabled;
  logic                  ctrl_write;
  logic                  timeout_ev;
  logic                  soft_ev;
  logic                  halt_ev;
  logic                  trigger;
  logic                  pulse_busy;
  logic                  pulse_n;
  rwd_halt_t             halt_state;
  logic                  frozen_done;
  logic [12:0]           wake_count;
  logic                  count_en;
  logic [NUM_EVENTS-1:0] status;
  logic [NUM_EVENTS-1:0] int_en;
  logic [NUM_EVENTS-1:0] events;

  // Two-stage synchronisers for options and halt/wake signals
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      hw_opt_sync   <= 2'b00;
      halt_opt_sync <= 2'b00;
      oie_sync      <= 2'b00;
      halt_sync     <= 2'b00;
      wake_sync     <= 2'b00;
      long_sync     <= 2'b00;
    end else begin
      hw_opt_sync   <= {hw_opt_sync[0], HW_WATCHDOG_OPT_IN};
      halt_opt_sync <= {halt_opt_sync[0], HALT_RESET_OPT_IN};
      oie_sync      <= {oie_sync[0], OSC_INT_ENABLE_IN};
      halt_sync     <= {halt_sync[0], HALT_IN};
      wake_sync     <= {wake_sync[0], EXT_WAKE_IN};
      long_sync     <= {long_sync[0], WAKE_LONG_IN};
    end
  end

  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      halt_prev <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      halt_prev <= halt_sync[1];
      wake_prev <= wake_sync[1];
    end
  end

  assign halt_edge  = halt_sync[1] && !halt_prev;
  assign wake_edge  = wake_sync[1] && !wake_prev;
  assign ctrl_write = WRITE_IN && ADDR_IN == ADDR_CONTROL;

  // Prescaler free-runs; a control write leaves its phase alone
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      prescale <= 14'h0000;
    end else if (count_en) begin
      prescale <= prescale + 14'h0001;
    end
  end

  assign tick = count_en && prescale == 14'(PRESCALE_CYCLES - 1);

  // Halt handling when halt option and oscillator interrupt enable are both clear
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      halt_state  <= RWD_RUN;
      frozen_done <= 1'b0;
      wake_count  <= 13'h0000;
    end else begin
      case (halt_state)
        RWD_RUN: begin
          if (halt_edge && !halt_opt_sync[1] && !oie_sync[1]) begin
            halt_state  <= RWD_FROZEN;
            frozen_done <= 1'b0;
          end
        end
        RWD_FROZEN: begin
          frozen_done <= 1'b1;
          if (wake_edge) begin
            halt_state <= RWD_WAKE;
            wake_count <= long_sync[1] ? 13'(WAKE_LONG_CLKS - 1) : 13'(WAKE_SHORT_CLKS - 1);
          end
        end
        RWD_WAKE: begin
          if (wake_count == 13'h0000) begin
            halt_state <= RWD_RUN;
          end else begin
            wake_count <= wake_count - 13'h0001;
          end
        end
        default: halt_state <= RWD_RUN;
      endcase
    end
  end

  // Frozen state allows one decrement on entry, then stops
  assign count_en = (halt_state == RWD_RUN) || (halt_state == RWD_FROZEN && !frozen_done);

  // Counter: free-running, loaded by a control write
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      counter <= COUNT_RESET;
    end else if (ctrl_write) begin
      counter <= WDATA_IN[TOP_BIT:0];
    end else if (halt_state == RWD_FROZEN && !frozen_done) begin
      counter <= counter - 7'h01;
    end else if (tick) begin
      counter <= counter - 7'h01;
    end
  end

  // Enable only sets; reset clears it, then the hardware option sets it again after reset
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      enabled    <= 1'b0;
      opt_loaded <= 1'b0;
    end else begin
      opt_loaded <= 1'b1;
      if ((ctrl_write && WDATA_IN[ENABLE_BIT]) || (opt_loaded && hw_opt_sync[1])) begin
        enabled <= 1'b1;
      end
    end
  end

  // Frozen watchdog cannot time out
  assign timeout_ev = enabled && tick && counter == COUNT_ROLL && halt_state == RWD_RUN;
  assign soft_ev    = ctrl_write && WDATA_IN[ENABLE_BIT] && !WDATA_IN[TOP_BIT];
  assign halt_ev    = halt_edge && (enabled || halt_opt_sync[1]) && !(oie_sync[1] && !halt_opt_sync[1])
                      && (halt_opt_sync[1] || enabled);
  assign trigger    = timeout_ev || soft_ev || halt_ev;
  assign events     = {halt_ev, soft_ev, timeout_ev};

  rwd_pulse u_pulse (
    .clk_in      (MCLK_IN),
    .reset_in    (RESET_IN),
    .trigger_in  (trigger),
    .reset_n_out (pulse_n),
    .busy_out    (pulse_busy)
  );

  // Open-drain reset pin: enable low drives the pin low
  assign RESET_N_OUT    = 1'b0;
  assign RESET_OE_N_OUT = pulse_n;

  // Sticky event status; a new event wins over a clear
  genvar g;
  generate
    for (g = 0; g < NUM_EVENTS; g++) begin : g_status
      always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
          status[g] <= 1'b0;
        end else if (events[g]) begin
          status[g] <= 1'b1;
        end else if (WRITE_IN && ADDR_IN == ADDR_INT_CLEAR && WDATA_IN[g]) begin
          status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      int_en <= '0;
    end else if (WRITE_IN && ADDR_IN == ADDR_INT_EN) begin
      int_en <= WDATA_IN[NUM_EVENTS-1:0];
    end
  end

  assign IRQ_OUT = |(status & int_en);

  // Read data in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (READ_IN) begin
      case (ADDR_IN)
        ADDR_CONTROL:  RDATA_OUT <= {enabled, counter};
        ADDR_STATUS:   RDATA_OUT <= {pulse_busy, 4'h0, status};
        ADDR_INT_EN:   RDATA_OUT <= {5'h00, int_en};
        default:       RDATA_OUT <= 8'h00;
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end
endmodule // rwd_top
`default_nettype wire

// ===== rwd_pkg.sv
// Package for the refreshable watchdog: register map, field layout, timing counts.
// Assumes a 10 MHz block clock standing in for the internal oscillator clock.
package rwd_pkg;
  localparam int unsigned CLK_HZ           = 10000000;
  localparam int unsigned PRESCALE_CYCLES  = 16384;
  localparam int unsigned RST_PULSE_NS     = 30000;
  localparam int unsigned RST_PULSE_CYCLES = (RST_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned WAKE_SHORT_CLKS  = 256;
  localparam int unsigned WAKE_LONG_CLKS   = 4096;

  localparam logic [3:0] ADDR_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_INT_EN    = 4'h2;
  localparam logic [3:0] ADDR_INT_CLEAR = 4'h3;

  localparam int unsigned ENABLE_BIT  = 7;
  localparam int unsigned TOP_BIT     = 6;
  localparam logic [6:0]  COUNT_RESET = 7'h7f;
  localparam logic [6:0]  COUNT_ROLL  = 7'h40;

  localparam int unsigned EV_TIMEOUT  = 0;
  localparam int unsigned EV_SOFT     = 1;
  localparam int unsigned EV_HALT     = 2;
  localparam int unsigned NUM_EVENTS  = 3;

  typedef enum logic [1:0] {
    RWD_RUN    = 2'b00,
    RWD_FROZEN = 2'b01,
    RWD_WAKE   = 2'b10
  } rwd_halt_t;
endpackage : rwd_pkg

// ===== rwd_pulse.sv
// Reset pulse stretcher: a trigger starts a fixed low pulse on the reset pin.
// Assumes the trigger is synchronous to the block clock.
`timescale 1ns/1ps
`default_nettype none
module rwd_pulse
  import rwd_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic trigger_in,
  output logic      reset_n_out,
  output logic      busy_out
);
  logic [15:0] remain;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      remain <= 16'h0000;
    end else if (trigger_in && remain == 16'h0000) begin
      remain <= 16'(RST_PULSE_CYCLES);
    end else if (remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reset_n_out <= 1'b1;
    end else begin
      reset_n_out <= !(remain > 16'h0001 || (trigger_in && remain == 16'h0000));
    end
  end

  assign busy_out = (remain != 16'h0000);
endmodule // rwd_pulse
`default_nettype wire

// ===== rwd_asserts.sv
// Checker for the watchdog top: read timing, reset pulse, interrupt.
// Bound to rwd_top by the testbench; sees top ports only.
`timescale 1ns/1ps
`default_nettype none
module rwd_asserts
  import rwd_pkg::*;
(
  input wire logic       MCLK_IN,
  input wire logic       RESET_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WRITE_IN,
  input wire logic       READ_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       RESET_N_OUT,
  input wire logic       RESET_OE_N_OUT,
  input wire logic       IRQ_OUT
);
  logic [9:0] low_cnt;
  logic       rd_ctl;
  logic       seen_en;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  // Counter, not repetition: 300 cycles is too long to unroll
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) low_cnt <= 10'h000;
    else if (!RESET_OE_N_OUT) low_cnt <= low_cnt + 10'h001;
    else low_cnt <= 10'h000;
  end
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rd_ctl <= 1'b0;
      seen_en <= 1'b0;
    end else begin
      rd_ctl <= READ_IN && ADDR_IN == ADDR_CONTROL;
      if (rd_ctl && RDATA_OUT[ENABLE_BIT]) seen_en <= 1'b1;
    end
  end
  property p_rd_idle; !$past(READ_IN) |-> RDATA_OUT == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmap; READ_IN && ADDR_IN > ADDR_INT_CLEAR |=> RDATA_OUT == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_soft;
    WRITE_IN && ADDR_IN == ADDR_CONTROL && WDATA_IN[7:6] == 2'b10 && RESET_OE_N_OUT |-> ##[1:2] !RESET_OE_N_OUT;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset write gave no pulse");
  property p_pulse; $rose(RESET_OE_N_OUT) |-> low_cnt == 10'(RST_PULSE_CYCLES); endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
  property p_oe_rst; @(posedge MCLK_IN) disable iff (1'b0) RESET_IN |-> RESET_OE_N_OUT && !IRQ_OUT; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("outputs active in reset");
  property p_drain; RESET_N_OUT == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("reset pin data not low");
  property p_sticky; rd_ctl && seen_en |-> RDATA_OUT[ENABLE_BIT]; endproperty
  a_sticky: assert property (p_sticky) else $error("enable bit cleared");
  property p_irq_off; WRITE_IN && ADDR_IN == ADDR_INT_EN && WDATA_IN == 8'h00 |=> !IRQ_OUT; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high with all masked");
  c_soft: cover property (WRITE_IN && ADDR_IN == ADDR_CONTROL && WDATA_IN[7:6] == 2'b10);
  c_pulse: cover property ($rose(RESET_OE_N_OUT));
  c_irq: cover property (IRQ_OUT);
endmodule // rwd_asserts
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for rwd_top: counting, soft, halt, hardware enable.
// Prescaler is fixed at 16384, so only a few ticks are run.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rwd_pkg::*;
  // Reset starts unknown so its first assignment makes an edge
  logic       mclk = 0, rst, wr_s = 0, rd_s = 0, hw = 0, hopt = 0, oscillator_interrupt_enable = 0;
  logic       halt = 0, wake = 0, wlong = 0, rst_n, oe_n, irq;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, d;
  int         failures = 0, compares = 0;
  always #50 mclk = ~mclk;
  rwd_top u_dut(.MCLK_IN(mclk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WRITE_IN(wr_s), .READ_IN(rd_s), .RDATA_OUT(rdata), .HW_WATCHDOG_OPT_IN(hw),
    .HALT_RESET_OPT_IN(hopt), .OSC_INT_ENABLE_IN(oscillator_interrupt_enable), .HALT_IN(halt), .EXT_WAKE_IN(wake),
    .WAKE_LONG_IN(wlong), .RESET_N_OUT(rst_n), .RESET_OE_N_OUT(oe_n), .IRQ_OUT(irq));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a; wdata <= v; wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a; rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // Waits for the pin to go low, then counts its low cycles
  task automatic pulse(input int lim);
    int n;
    n = 0;
    while (oe_n !== 1'b0 && n < lim) begin @(negedge mclk); n++; end
    chk(n < lim, 1);
    if (n >= lim) end_of_test();
    n = 0;
    while (oe_n === 1'b0 && n < 400) begin @(negedge mclk); n++; end
    chk(n, RST_PULSE_CYCLES);
    if (n >= 400) end_of_test();
  endtask
  task automatic s_reset;
    rd(ADDR_CONTROL, d); chk(d, 8'h7f);
    rd(ADDR_STATUS, d); chk(d, 8'h00);
    rd(4'h9, d); chk(d, 8'h00);
  endtask
  // A mid-period write must not move the next tick
  task automatic s_count;
    int n;
    n = 0;
    d = 8'h7f;
    // First tick lands about 16384 cycles after reset, two cycles per read
    while (d === 8'h7f && n < 9000) begin rd(ADDR_CONTROL, d); n++; end
    chk(d, 8'h7e);
    if (n >= 9000) end_of_test();
    repeat (8000) @(posedge mclk);
    wr(ADDR_CONTROL, 8'h7f);
    repeat (8360) @(posedge mclk);
    rd(ADDR_CONTROL, d); chk(d, 8'h7f);
    n = 0;
    while (d === 8'h7f && n < 20) begin rd(ADDR_CONTROL, d); n++; end
    chk(d, 8'h7e);
    if (n >= 20) end_of_test();
  endtask
  task automatic s_soft;
    wr(ADDR_INT_EN, 8'h07);
    wr(ADDR_CONTROL, 8'h80);
    pulse(4);
    rd(ADDR_STATUS, d); chk(d, 8'h02);
    chk(irq, 1);
    wr(ADDR_CONTROL, 8'h7f);
    rd(ADDR_CONTROL, d); chk(d, 8'hff);
    rd(ADDR_CONTROL, d); chk(d[7], 1);
    chk(oe_n, 1);
    wr(ADDR_INT_CLEAR, 8'h02);
    rd(ADDR_STATUS, d); chk(d, 8'h00);
    chk(irq, 0);
    wr(ADDR_INT_EN, 8'h00);
    do_reset();
    rd(ADDR_CONTROL, d); chk(d, 8'h7f);
  endtask
  // Halt with option and oscillator interrupt clear freezes the counter
  task automatic s_halt;
    @(posedge mclk);
    halt <= 1'b1;
    repeat (300) @(posedge mclk);
    rd(ADDR_CONTROL, d); chk(d, 8'h7e);
    rd(ADDR_STATUS, d); chk(d, 8'h00);
    @(posedge mclk);
    wake <= 1'b1;
    repeat (270) @(posedge mclk);
    halt <= 1'b0;
    wake <= 1'b0;
    hopt <= 1'b1;
    repeat (4) @(posedge mclk);
    halt <= 1'b1;
    pulse(10);
    rd(ADDR_STATUS, d); chk(d, 8'h04);
    @(posedge mclk);
    halt <= 1'b0;
    hopt <= 1'b0;
  endtask
  // Hardware enable, then a refresh to 40h that times out on the next tick
  task automatic s_hw;
    @(posedge mclk);
    hw <= 1'b1;
    do_reset();
    rd(ADDR_CONTROL, d); chk(d, 8'hff);
    wr(ADDR_CONTROL, 8'hc0);
    pulse(17000);
    rd(ADDR_STATUS, d); chk(d, 8'h01);
  endtask
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    do_reset();
    s_reset();
    s_count();
    s_soft();
    s_halt();
    s_hw();
    end_of_test();
  end
endmodule // testbench
bind rwd_top rwd_asserts u_chk (
  .MCLK_IN        (MCLK_IN),
  .RESET_IN       (RESET_IN),
  .ADDR_IN        (ADDR_IN),
  .WDATA_IN       (WDATA_IN),
  .WRITE_IN       (WRITE_IN),
  .READ_IN        (READ_IN),
  .RDATA_OUT      (RDATA_OUT),
  .RESET_N_OUT    (RESET_N_OUT),
  .RESET_OE_N_OUT (RESET_OE_N_OUT),
  .IRQ_OUT        (IRQ_OUT)
);
`default_nettype wire
